// file: hw/cdcp_cfg.svh
// constants for the character display command port
`ifndef CDCP_CFG_SVH
`define CDCP_CFG_SVH

// clock and execution timing
`define CDCP_CLK_MHZ 250
`define CDCP_CLR_TIME_NS 6200000
`define CDCP_CLR_CYCLES ((`CDCP_CLR_TIME_NS * `CDCP_CLK_MHZ) / 1000)
`define CDCP_EXEC_TIME_NS 40
`define CDCP_EXEC_CYCLES (((`CDCP_EXEC_TIME_NS * `CDCP_CLK_MHZ) + 999) / 1000)
`define CDCP_CNT_W 21

// memories and buffer
`define CDCP_TEXT_DEPTH 128
`define CDCP_GLYPH_DEPTH 64
`define CDCP_BLANK_CODE 8'h20
`define CDCP_BUF_WIDTH 10
`define CDCP_SERIAL_BITS 4'hA

// instruction codes and prefixes
`define CDCP_OP_CLEAR 8'h01
`define CDCP_OP_NONE 8'h00
`define CDCP_OP_HOME 7'h01
`define CDCP_OP_ENTRY 6'h01
`define CDCP_OP_CTRL 5'h01
`define CDCP_OP_SHIFT 4'h1
`define CDCP_OP_FUNC 3'h1
`define CDCP_OP_GADDR 2'h1
`define CDCP_SUB_SHIFT 2'h0
`define CDCP_SUB_MODE 2'h3

// field positions
`define CDCP_BIT_SC 3
`define CDCP_BIT_RL 2
`define CDCP_BIT_DL 4

// reset values
`define CDCP_PIN_RST 16'h1802
`define CDCP_RST_WIDE 1'b1
`define CDCP_RST_INC 1'b1
`define CDCP_RST_POWER 1'b0

`endif

// file: hw/cdcp_pkg.sv
// types for the character display command port
package cdcp_pkg;

	typedef enum logic [2:0] {
		CDCP_IDLE = 3'h1,
		CDCP_RUN = 3'h2,
		CDCP_CLR = 3'h4
	} cdcp_state_t;

	typedef enum logic [1:0] {
		CDCP_BUS_8080 = 2'h0,
		CDCP_BUS_6800 = 2'h1,
		CDCP_BUS_SERIAL = 2'h2
	} cdcp_bus_t;

endpackage

// file: hw/cdcp_two_entry_buffer.sv
// two-entry valid/ready buffer between host front end and executor
`timescale 1ns/1ps
`default_nettype none

module cdcp_two_entry_buffer
#(
	parameter int unsigned WIDTH = 10
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);

	logic [WIDTH-1:0] slot0;
	logic [WIDTH-1:0] slot1;
	logic [1:0] count;
	logic push;
	logic pop;

	// handshake terms, head entry always in slot0
	assign inReady = (count != 2'h2);
	assign outValid = (count != 2'h0);
	assign outData = slot0;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// occupancy
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			count <= 2'h0;
		else if (push && !pop)
			count <= count + 2'h1;
		else if (pop && !push)
			count <= count - 2'h1;
	end

	// storage, slot1 moves forward on pop
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			slot0 <= '0;
			slot1 <= '0;
		end
		else
		begin
			if (pop)
				slot0 <= (count == 2'h2) ? slot1 : inData;
			else if (push && count == 2'h0)
				slot0 <= inData;
			if (push && !pop && count == 2'h1)
				slot1 <= inData;
		end
	end

endmodule
`default_nettype wire

// file: hw/cdcp_command_port.sv
// host command interpreter of the character display controller
`timescale 1ns/1ps
`default_nettype none
`include "cdcp_cfg.svh"
// Functional notes
// - only instruction and data registers are host visible
// - while busy only status read is accepted
// - busy stays high for whole execution
// - clear blanks text, zeroes address counter
// - home zeroes counter and shift, keeps text
// - entry mode latches direction and shift
// - display control latches display, cursor, blink
// - shift moves cursor or display, RAM untouched
// - mode/power latches graphic mode and power
// - function set latches width, lines, font, table
// - glyph address load selects glyph RAM
// - text address load selects text RAM
// - status read returns busy and counter
// - data write stores into selected RAM
// - data read returns selected RAM byte
// - counter steps after each data write
// - entry shift happens with a text RAM data write or read
// - 8080, 6800 or serial host transfers
// - stepped counter visible after busy clears
// - direction bit chooses increment or decrement
// - shift codes: cursor step or display shift
// - clear forces increment, keeps shift bit
module cdcp_command_port
#(
	parameter int unsigned CLEAR_CYCLES = `CDCP_CLR_CYCLES
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [1:0] busModePin,
	input wire logic registerSelect,
	input wire logic writeStrobePin,
	input wire logic enableReadStrobePin,
	input wire logic [7:0] dataIn,
	output logic [7:0] dataOut,
	output logic dataOe,
	input wire logic serialClockPin,
	input wire logic serialSelectN,
	input wire logic serialInPin,
	output logic serialOutPin,
	output logic serialOutOe,
	output logic busyIndication,
	output logic [6:0] addressCounter,
	output logic glyphRamSelected,
	output logic displayOn,
	output logic cursorOn,
	output logic blinkOn,
	output logic entryIncrement,
	output logic entryShift,
	output logic graphicMode,
	output logic powerOn,
	output logic busWidthSelect,
	output logic twoLines,
	output logic tallFont,
	output logic glyphTableHi,
	output logic glyphTableLo,
	output logic [6:0] displayShift
);

	logic [15:0] pinS1, pinS2, pinS3, pinF;
	cdcp_pkg::cdcp_bus_t busMode;
	logic rsF, wrF, rdF, sclkF, sselF, sinF;
	logic [7:0] dF;
	logic parActive, parRnw, prevActive, armed, parEnd, parEv;
	logic capRs, capRnw, nibblePhase;
	logic [7:0] capData;
	logic [3:0] hiNibble;
	logic sclkPrev, serRise, serEv;
	logic [3:0] bitCnt;
	logic [9:0] shiftIn;
	logic [7:0] outShift;
	logic evValid, evRs, evRnw, pushReq, bufPush, bufInReady, bufOutValid, bufPop;
	logic [7:0] evData, qD, ramRd, readByte, lastCmd;
	logic [9:0] bufOut;
	logic qRs, qRnw, popCmd;
	logic isClear, isHome, isEntry, isCtrl, isShift, isModePwr, isFunc;
	logic isGlyphAdr, isTextAdr, isWrite, isRead;
	logic [6:0] ac;
	logic [7:0] clrIdx;
	logic [`CDCP_CNT_W-1:0] cnt;
	cdcp_pkg::cdcp_state_t state;
	logic [7:0] textRam [`CDCP_TEXT_DEPTH];
	logic [7:0] glyphRam [`CDCP_GLYPH_DEPTH];

	// counter step with wrap inside the selected RAM
	function automatic logic [6:0] stepAc(input logic [6:0] a, input logic up, input logic glyph);
		logic [6:0] n;
		n = up ? a + 7'h01 : a - 7'h01;
		stepAc = glyph ? {1'b0, n[5:0]} : n;
	endfunction

	// three-stage pin synchroniser, a change counts once stages two and three agree
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			pinS1 <= `CDCP_PIN_RST;
			pinS2 <= `CDCP_PIN_RST;
			pinS3 <= `CDCP_PIN_RST;
			pinF <= `CDCP_PIN_RST;
		end
		else
		begin
			pinS1 <= {busModePin, registerSelect, writeStrobePin, enableReadStrobePin,
				dataIn, serialClockPin, serialSelectN, serialInPin};
			pinS2 <= pinS1;
			pinS3 <= pinS2;
			pinF <= (~(pinS2 ^ pinS3) & pinS3) | ((pinS2 ^ pinS3) & pinF);
		end
	end

	assign busMode = cdcp_pkg::cdcp_bus_t'(pinF[15:14]);
	assign rsF = pinF[13];
	assign wrF = pinF[12];
	assign rdF = pinF[11];
	assign dF = pinF[10:3];
	assign sclkF = pinF[2];
	assign sselF = pinF[1];
	assign sinF = pinF[0];

	// parallel strobes: 6800 uses enable plus read/write, 8080 two low strobes
	always_comb
	begin
		parActive = 1'b0;
		parRnw = 1'b0;
		case (busMode)
			cdcp_pkg::CDCP_BUS_6800:
			begin
				parActive = rdF;
				parRnw = wrF;
			end
			cdcp_pkg::CDCP_BUS_8080:
			begin
				parActive = !wrF || !rdF;
				parRnw = !rdF;
			end
			default:
			begin
				parActive = 1'b0;
				parRnw = 1'b0;
			end
		endcase
	end

	assign parEnd = armed && prevActive && !parActive;
	assign parEv = parEnd && (busWidthSelect || nibblePhase);

	// capture select, direction and data while the strobe is active
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			prevActive <= 1'b1;
			armed <= 1'b0;
			capRs <= 1'b0;
			capRnw <= 1'b0;
			capData <= 8'h00;
		end
		else
		begin
			prevActive <= parActive;
			if (!prevActive && parActive)
				armed <= 1'b1;
			else if (parEnd)
				armed <= 1'b0;
			if (parActive)
			begin
				capRs <= rsF;
				capRnw <= parRnw;
				capData <= dF;
			end
		end
	end

	// four-bit mode nibble pairing, high nibble first on the upper lines
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			nibblePhase <= 1'b0;
			hiNibble <= 4'h0;
		end
		else if (busWidthSelect)
			nibblePhase <= 1'b0;
		else if (parEnd)
		begin
			nibblePhase <= !nibblePhase;
			if (!nibblePhase)
				hiNibble <= capData[7:4];
		end
	end

	// serial frame: select, read/write, then eight data bits, msb first
	assign serRise = sclkF && !sclkPrev && !sselF && busMode == cdcp_pkg::CDCP_BUS_SERIAL;
	assign serEv = serRise && bitCnt == `CDCP_SERIAL_BITS - 4'h1;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			sclkPrev <= 1'b0;
			bitCnt <= 4'h0;
			shiftIn <= 10'h000;
			outShift <= 8'h00;
		end
		else
		begin
			sclkPrev <= sclkF;
			if (sselF)
				bitCnt <= 4'h0;
			else if (serRise)
			begin
				shiftIn <= {shiftIn[8:0], sinF};
				bitCnt <= (bitCnt == `CDCP_SERIAL_BITS) ? 4'h1 : bitCnt + 4'h1;
				if (bitCnt == 4'h1 && sinF)
					outShift <= shiftIn[0] ? ramRd : {busyIndication, addressCounter};
				else if (bitCnt >= 4'h2)
					outShift <= {outShift[6:0], 1'b0};
			end
		end
	end

	// one event stream from whichever port completed a transfer
	assign evValid = parEv || serEv;
	assign evRs = serEv ? shiftIn[8] : capRs;
	assign evRnw = serEv ? shiftIn[7] : capRnw;
	assign evData = serEv ? {shiftIn[6:0], sinF} : (busWidthSelect ? capData :
		{hiNibble, capData[7:4]});
	// status reads need no work, everything else is dropped while busy
	assign pushReq = evValid && !(!evRs && evRnw);
	assign bufPush = pushReq && !busyIndication && bufInReady;

	cdcp_two_entry_buffer #(
		.WIDTH(`CDCP_BUF_WIDTH)
	) u_buffer (
		.clock(clock),
		.nrst(nrst),
		.inValid(bufPush),
		.inData({evRs, evRnw, evData}),
		.inReady(bufInReady),
		.outValid(bufOutValid),
		.outData(bufOut),
		.outReady(state == cdcp_pkg::CDCP_IDLE)
	);

	// instruction decode of the popped word
	assign bufPop = bufOutValid && state == cdcp_pkg::CDCP_IDLE;
	assign qRs = bufOut[9];
	assign qRnw = bufOut[8];
	assign qD = bufOut[7:0];
	assign popCmd = bufPop && !qRs && !qRnw;
	assign isClear = popCmd && qD == `CDCP_OP_CLEAR;
	assign isHome = popCmd && qD[7:1] == `CDCP_OP_HOME;
	assign isEntry = popCmd && qD[7:2] == `CDCP_OP_ENTRY;
	assign isCtrl = popCmd && qD[7:3] == `CDCP_OP_CTRL;
	assign isShift = popCmd && qD[7:4] == `CDCP_OP_SHIFT && qD[1:0] == `CDCP_SUB_SHIFT;
	assign isModePwr = popCmd && qD[7:4] == `CDCP_OP_SHIFT && qD[1:0] == `CDCP_SUB_MODE;
	assign isFunc = popCmd && qD[7:5] == `CDCP_OP_FUNC;
	assign isGlyphAdr = popCmd && qD[7:6] == `CDCP_OP_GADDR;
	assign isTextAdr = popCmd && qD[7];
	assign isWrite = bufPop && qRs && !qRnw;
	assign isRead = bufPop && qRs && qRnw;
	assign busyIndication = (state != cdcp_pkg::CDCP_IDLE) || bufOutValid;

	// execution sequencer, clear also sweeps blanks through text RAM
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= cdcp_pkg::CDCP_IDLE;
			cnt <= '0;
			clrIdx <= 8'h00;
		end
		else
		begin
			case (state)
				cdcp_pkg::CDCP_IDLE:
				begin
					if (isClear)
					begin
						state <= cdcp_pkg::CDCP_CLR;
						cnt <= `CDCP_CNT_W'(CLEAR_CYCLES);
						clrIdx <= 8'h00;
					end
					else if (bufPop)
					begin
						state <= cdcp_pkg::CDCP_RUN;
						cnt <= `CDCP_CNT_W'(`CDCP_EXEC_CYCLES);
					end
				end
				cdcp_pkg::CDCP_RUN:
				begin
					if (cnt <= `CDCP_CNT_W'(1))
						state <= cdcp_pkg::CDCP_IDLE;
					else
						cnt <= cnt - `CDCP_CNT_W'(1);
				end
				cdcp_pkg::CDCP_CLR:
				begin
					if (!clrIdx[7])
						clrIdx <= clrIdx + 8'h01;
					if (cnt > `CDCP_CNT_W'(1))
						cnt <= cnt - `CDCP_CNT_W'(1);
					else if (clrIdx[7])
						state <= cdcp_pkg::CDCP_IDLE;
				end
				default:
					state <= cdcp_pkg::CDCP_IDLE;
			endcase
		end
	end

	// mode latches set by instructions
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			entryIncrement <= `CDCP_RST_INC;
			entryShift <= 1'b0;
			{displayOn, cursorOn, blinkOn} <= 3'h0;
			graphicMode <= 1'b0;
			powerOn <= `CDCP_RST_POWER;
			busWidthSelect <= `CDCP_RST_WIDE;
			{twoLines, tallFont, glyphTableHi, glyphTableLo} <= 4'h0;
		end
		else
		begin
			if (isClear)
				entryIncrement <= 1'b1;
			else if (isEntry)
			begin
				entryIncrement <= qD[1];
				entryShift <= qD[0];
			end
			if (isCtrl)
				{displayOn, cursorOn, blinkOn} <= qD[2:0];
			if (isModePwr)
			begin
				graphicMode <= qD[`CDCP_BIT_SC];
				powerOn <= qD[`CDCP_BIT_RL];
			end
			if (isFunc)
			begin
				busWidthSelect <= qD[`CDCP_BIT_DL];
				{twoLines, tallFont, glyphTableHi, glyphTableLo} <= qD[3:0];
			end
		end
	end

	// address counter, RAM target and display shift offset
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			ac <= 7'h00;
			glyphRamSelected <= 1'b0;
			displayShift <= 7'h00;
		end
		else if (isClear || isHome)
		begin
			ac <= 7'h00;
			glyphRamSelected <= 1'b0;
			displayShift <= 7'h00;
		end
		else if (isGlyphAdr)
		begin
			ac <= {1'b0, qD[5:0]};
			glyphRamSelected <= 1'b1;
		end
		else if (isTextAdr)
		begin
			ac <= qD[6:0];
			glyphRamSelected <= 1'b0;
		end
		else if (isShift && !qD[`CDCP_BIT_SC])
			ac <= stepAc(ac, qD[`CDCP_BIT_RL], glyphRamSelected);
		else if (isShift)
			displayShift <= qD[`CDCP_BIT_RL] ? displayShift + 7'h01 : displayShift - 7'h01;
		else if (isWrite || isRead)
		begin
			ac <= stepAc(ac, entryIncrement, glyphRamSelected);
			if (entryShift && !glyphRamSelected)
				displayShift <= entryIncrement ? displayShift - 7'h01 : displayShift + 7'h01;
		end
	end

	// text and glyph RAM writes
	always_ff @(posedge clock)
	begin
		if (state == cdcp_pkg::CDCP_CLR && !clrIdx[7])
			textRam[clrIdx[6:0]] <= `CDCP_BLANK_CODE;
		else if (isWrite && !glyphRamSelected)
			textRam[ac] <= qD;
		if (isWrite && glyphRamSelected)
			glyphRam[ac[5:0]] <= qD;
	end

	// read path: RAM prefetch, visible counter and pin data register
	assign readByte = rsF ? ramRd : {busyIndication, addressCounter};
	assign dataOe = parActive && parRnw;
	assign serialOutOe = !sselF && busMode == cdcp_pkg::CDCP_BUS_SERIAL;
	assign serialOutPin = outShift[7];

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			ramRd <= 8'h00;
			addressCounter <= 7'h00;
			dataOut <= 8'h00;
			lastCmd <= 8'h00;
		end
		else
		begin
			ramRd <= glyphRamSelected ? glyphRam[ac[5:0]] : textRam[ac];
			if (!busyIndication)
				addressCounter <= ac;
			dataOut <= busWidthSelect ? readByte :
				{(nibblePhase ? readByte[3:0] : readByte[7:4]), 4'h0};
			lastCmd <= qD;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	AST_BUSY_HOLDS: assert property ((bufPop && !isClear) |-> busyIndication[*8])
		else $error("busy dropped during execution");
	AST_BUSY_IGNORED: assert property ((busyIndication && evValid) |=> !bufOutValid)
		else $error("transfer taken while busy");
	AST_CLEAR_EFFECT: assert property (isClear |=>
		ac == 7'h00 && entryIncrement && busyIndication)
		else $error("clear did not reset counter or direction");
	AST_HOME_EFFECT: assert property (isHome |=>
		ac == 7'h00 && displayShift == 7'h00 && !glyphRamSelected)
		else $error("home did not reset counter and shift");
	AST_WRITE_STEP: assert property ((isWrite && entryIncrement && !glyphRamSelected) |=>
		ac == $past(ac) + 7'h01)
		else $error("counter not stepped after write");
	AST_COUNTER_HIDDEN: assert property ((busyIndication && $past(busyIndication)) |->
		$stable(addressCounter))
		else $error("counter changed while busy");
	AST_STATUS_BYTE: assert property ((!rsF && busWidthSelect) |=>
		dataOut == {$past(busyIndication), $past(addressCounter)})
		else $error("status read byte wrong");
	AST_UNLISTED: assert property ((popCmd && qD == `CDCP_OP_NONE) |=>
		$stable(ac) && $stable(displayOn) && $stable(busWidthSelect))
		else $error("unlisted code changed state");
	AST_CTRL_LATCH: assert property (isCtrl |=> {displayOn, cursorOn, blinkOn} == lastCmd[2:0])
		else $error("display control bits not latched");

	COV_CLEAR_DONE: cover property (state == cdcp_pkg::CDCP_CLR ##1 state == cdcp_pkg::CDCP_IDLE);
	COV_NIBBLE_WRITE: cover property (parEv && !busWidthSelect && evRs && !evRnw);
	COV_SERIAL_EVENT: cover property (serEv && bufPush);

endmodule
`default_nettype wire

// file: dv/cdcp_host_model.sv
// host processor model driving the command port pins
`timescale 1ns/1ps
`default_nettype none

module cdcp_host_model
(
	input wire logic clock,
	input wire logic nibbleMode,
	input wire logic [7:0] busIn,
	input wire logic serialOutPin,
	output logic [1:0] busModePin,
	output logic registerSelect,
	output logic writeStrobePin,
	output logic enableReadStrobePin,
	output logic [7:0] hostData,
	output logic serialClockPin,
	output logic serialSelectN,
	output logic serialInPin
);
	// idle levels, 8080 port active, serial clock parked
	initial
	begin
		busModePin = 2'h0;
		registerSelect = 1'b0;
		writeStrobePin = 1'b1;
		enableReadStrobePin = 1'b1;
		hostData = 8'h00;
		serialClockPin = 1'b0;
		serialSelectN = 1'b1;
		serialInPin = 1'b0;
	end

	task automatic waitc(input int n);
		repeat (n) @(negedge clock);
	endtask

	// park pins while no port listens, so a switch fakes no strobe
	task automatic set_mode(input logic [1:0] m);
		waitc(1);
		busModePin = 2'h3;
		waitc(4);
		writeStrobePin = 1'b1;
		enableReadStrobePin = (m == 2'h0);
		waitc(4);
		busModePin = m;
		waitc(8);
	endtask

	// one parallel strobe; both buses share the pin pair
	task automatic phase(input logic rs, input logic rnw, input logic [7:0] d,
		output logic [7:0] q);
		waitc(1);
		registerSelect = rs;
		hostData = rnw ? ~hostData : d;
		writeStrobePin = (busModePin == 2'h1) ? rnw : 1'b1;
		waitc(1);
		if (busModePin == 2'h1)
			enableReadStrobePin = 1'b1;
		else
		begin
			writeStrobePin = rnw;
			enableReadStrobePin = ~rnw;
		end
		waitc(8);
		q = busIn;
		enableReadStrobePin = (busModePin != 2'h1);
		if (busModePin != 2'h1)
			writeStrobePin = 1'b1;
		waitc(4);
		writeStrobePin = 1'b1;
		hostData = ~hostData;
	endtask

	// whole byte: serial frame, two nibbles or one parallel strobe
	task automatic xfer(input logic rs, input logic rnw, input logic [7:0] d,
		output logic [7:0] q);
		logic [7:0] hi;
		logic [9:0] f;
		f = {rs, rnw, d};
		q = 8'h00;
		if (busModePin == 2'h2)
		begin
			waitc(1);
			serialSelectN = 1'b0;
			for (int i = 0; i < 10; i++)
			begin
				serialInPin = f[9 - i];
				waitc(4);
				if (i >= 2)
					q[9 - i] = serialOutPin;
				serialClockPin = 1'b1;
				waitc(4);
				serialClockPin = 1'b0;
			end
			waitc(4);
			serialSelectN = 1'b1;
			serialInPin = ~serialInPin;
			waitc(4); // select high long enough to pass the pin filter
		end
		else if (nibbleMode)
		begin
			phase(rs, rnw, {d[7:4], 4'h0}, hi);
			phase(rs, rnw, {d[3:0], 4'h0}, q);
			q = {hi[7:4], q[7:4]};
		end
		else
			phase(rs, rnw, d, q);
	endtask
endmodule

`default_nettype wire

// file: dv/character_display_command_port_test.sv
// self-checking bench for the character display command port
`timescale 1ns/1ps
`default_nettype none

module character_display_command_port_test;
	logic clock;
	logic nrst;
	logic nibbleMode;
	logic [7:0] q;
	int errors;
	int tests_run;
	int busyCycles;
	int busyBase;
	wire logic [1:0] busModePin;
	wire logic registerSelect, writeStrobePin, enableReadStrobePin;
	wire logic serialClockPin, serialSelectN, serialInPin, serialOutPin, serialOutOe;
	wire logic [7:0] hostData, dataOut;
	wire logic dataOe, busyIndication, glyphRamSelected, displayOn, cursorOn, blinkOn;
	wire logic entryIncrement, entryShift, graphicMode, powerOn, busWidthSelect;
	wire logic twoLines, tallFont, glyphTableHi, glyphTableLo;
	wire logic [6:0] addressCounter, displayShift;
	// data lines and serial out as the wire sees them
	wire logic [7:0] dataBus = dataOe ? dataOut : hostData;
	wire logic serialLine = serialOutOe ? serialOutPin : serialClockPin;
	wire logic [26:0] stateVec = {displayOn, cursorOn, blinkOn, entryIncrement, entryShift,
		graphicMode, powerOn, busWidthSelect, twoLines, tallFont, glyphTableHi,
		glyphTableLo, addressCounter, glyphRamSelected, displayShift};

	// instruction byte, then flags, counter, glyph select, shift it should leave
	localparam logic [34:0] ROWS [0:16] = '{
		{8'h0E, 12'hD10, 7'h00, 1'h0, 7'h00}, {8'h0D, 12'hB10, 7'h00, 1'h0, 7'h00},
		{8'h3F, 12'hB1F, 7'h00, 1'h0, 7'h00}, {8'h04, 12'hA1F, 7'h00, 1'h0, 7'h00},
		{8'h1F, 12'hA7F, 7'h00, 1'h0, 7'h00}, {8'h13, 12'hA1F, 7'h00, 1'h0, 7'h00},
		{8'h85, 12'hA1F, 7'h05, 1'h0, 7'h00}, {8'h14, 12'hA1F, 7'h06, 1'h0, 7'h00},
		{8'h10, 12'hA1F, 7'h05, 1'h0, 7'h00}, {8'h1C, 12'hA1F, 7'h05, 1'h0, 7'h01},
		{8'h18, 12'hA1F, 7'h05, 1'h0, 7'h00}, {8'h18, 12'hA1F, 7'h05, 1'h0, 7'h7F},
		{8'h4A, 12'hA1F, 7'h0A, 1'h1, 7'h7F},
		{8'h02, 12'hA1F, 7'h00, 1'h0, 7'h00}, // test bit held low
		{8'h06, 12'hB1F, 7'h00, 1'h0, 7'h00}, {8'h00, 12'hB1F, 7'h00, 1'h0, 7'h00},
		{8'h11, 12'hB1F, 7'h00, 1'h0, 7'h00}};

	cdcp_command_port #(.CLEAR_CYCLES(200)) dut_u (.clock, .nrst, .busModePin,
		.registerSelect, .writeStrobePin, .enableReadStrobePin, .dataIn(dataBus),
		.dataOut, .dataOe, .serialClockPin, .serialSelectN, .serialInPin,
		.serialOutPin, .serialOutOe, .busyIndication, .addressCounter, .glyphRamSelected,
		.displayOn, .cursorOn, .blinkOn, .entryIncrement, .entryShift, .graphicMode,
		.powerOn, .busWidthSelect, .twoLines, .tallFont, .glyphTableHi, .glyphTableLo,
		.displayShift);

	cdcp_host_model host_u (.clock, .nibbleMode, .busIn(dataBus), .serialOutPin(serialLine),
		.busModePin, .registerSelect, .writeStrobePin, .enableReadStrobePin, .hostData,
		.serialClockPin, .serialSelectN, .serialInPin);

	// free-running clock, 4 ns period
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// cycles with busy high, tests take a base value before measuring
	always @(posedge clock)
		if (busyIndication === 1'b1)
			busyCycles <= busyCycles + 1;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one transfer, then status polls until busy reads clear
	task automatic cmd(input logic rs, input logic rnw, input logic [7:0] d);
		int n;
		logic [7:0] s;
		host_u.xfer(rs, rnw, d, q);
		n = 0;
		s = 8'hFF;
		while (s[7] !== 1'b0 && n < 300)
		begin
			host_u.xfer(1'b0, 1'b1, 8'h00, s);
			n++;
		end
		check(n < 300, 1'b1);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog well beyond the expected run length
	initial
	begin
		#240000;
		errors++;
		end_of_test();
	end

	initial
	begin
		nrst = 1'b0;
		nibbleMode = 1'b0;
		errors = 0;
		tests_run = 0;
		busyBase = 0;
		repeat (5) @(posedge clock);
		@(negedge clock);
		nrst = 1'b1;
		check({busyIndication, stateVec}, {1'h0, 12'h110, 7'h00, 1'h0, 7'h00});
		$display("test reset done");
		foreach (ROWS[i])
		begin
			cmd(1'b0, 1'b0, ROWS[i][34:27]);
			check(stateVec, ROWS[i][26:0]);
		end
		$display("test instruction table done");
		// text and glyph writes, reads, stepping both ways
		cmd(1'b0, 1'b0, 8'h90);
		cmd(1'b1, 1'b0, 8'h41);
		cmd(1'b1, 1'b0, 8'h42);
		check(addressCounter, 7'h12);
		cmd(1'b0, 1'b0, 8'h90);
		cmd(1'b1, 1'b1, 8'h00);
		check({q, addressCounter}, {8'h41, 7'h11});
		cmd(1'b0, 1'b0, 8'h04);
		cmd(1'b0, 1'b0, 8'hA0);
		cmd(1'b1, 1'b0, 8'h55);
		check(addressCounter, 7'h1F);
		cmd(1'b0, 1'b0, 8'h06);
		cmd(1'b0, 1'b0, 8'h7F);
		cmd(1'b1, 1'b0, 8'h99);
		check({glyphRamSelected, addressCounter}, {1'h1, 7'h00});
		cmd(1'b0, 1'b0, 8'h7F);
		cmd(1'b1, 1'b1, 8'h00);
		check(q, 8'h99);
		cmd(1'b0, 1'b0, 8'h90);
		cmd(1'b1, 1'b1, 8'h00);
		check(q, 8'h41);
		$display("test ram access done");
		cmd(1'b0, 1'b0, 8'h07);
		cmd(1'b0, 1'b0, 8'h80);
		cmd(1'b1, 1'b0, 8'h43);
		check({addressCounter, displayShift}, {7'h01, 7'h7F});
		$display("test entry shift done");
		// clear with a status read and a dropped write inside its busy time
		cmd(1'b0, 1'b0, 8'h05);
		busyBase = busyCycles;
		host_u.xfer(1'b0, 1'b0, 8'h01, q);
		host_u.xfer(1'b0, 1'b1, 8'h00, q);
		check(q[7], 1'b1);
		cmd(1'b0, 1'b0, 8'h0F);
		check((busyCycles - busyBase) >= 200 && (busyCycles - busyBase) <= 205, 1'b1);
		check({displayOn, cursorOn, blinkOn, entryIncrement, entryShift}, 5'h17);
		host_u.xfer(1'b0, 1'b1, 8'h00, q);
		check({q, displayShift}, {8'h00, 7'h00});
		cmd(1'b0, 1'b0, 8'h90);
		cmd(1'b1, 1'b1, 8'h00);
		check(q, 8'h20);
		$display("test clear done");
		// four-bit transfers, back to eight bits
		cmd(1'b0, 1'b0, 8'h2C);
		nibbleMode = 1'b1;
		cmd(1'b0, 1'b0, 8'h0E);
		check({busWidthSelect, displayOn, cursorOn, blinkOn}, 4'h6);
		cmd(1'b0, 1'b0, 8'h90);
		cmd(1'b1, 1'b1, 8'h00);
		check(q, 8'h20);
		cmd(1'b0, 1'b0, 8'h3F);
		nibbleMode = 1'b0;
		check(busWidthSelect, 1'b1);
		$display("test nibble mode done");
		// 6800 and serial ports carry the same traffic
		for (int m = 1; m < 3; m++)
		begin
			host_u.set_mode(m[1:0]);
			cmd(1'b0, 1'b0, {6'h2C, m[1:0]});
			cmd(1'b1, 1'b0, {6'h28, m[1:0]});
			cmd(1'b0, 1'b0, {6'h2C, m[1:0]});
			cmd(1'b1, 1'b1, 8'h00);
			check(q, {6'h28, m[1:0]});
			host_u.xfer(1'b0, 1'b1, 8'h00, q);
			check(q, {6'h0C, m[1:0]} + 8'h01);
		end
		$display("test bus modes done");
		end_of_test();
	end
endmodule

`default_nettype wire
